// ---- hw/dcps_top.sv ----
// Display clock, mode and segment pin select, with an APB register slave.
// Assumes waveform generation and display RAM sit outside; oscillator
// levels and touch status arrive synchronous to pclk.
//
// How it works
// RULE1 - Clock source bit clear picks slow RC, set picks slow crystal.
// RULE2 - Prescaler code 00,01,10,11 divides by 256,128,64,32.
// RULE3 - Enable bit 0 hands segments 7..4 together to the display.
// RULE4 - Enable bit 1 hands segments 11..8 together to the display.
// RULE5 - Enable bits 2..7 each hand one pin, segments 12..17, over.
// RULE6 - Segment 9 shares the touch pin; avoid enabling it while sensing.
// RULE7 - LED select clear keeps LCD mode, set switches driver to LED mode.
// RULE8 - Polarity clear gives active-low high-sink commons, set active high.
// RULE9 - Dead time in LED mode blanks commons briefly before each change.
// RULE10 - Display enable clear turns the driver off, set turns it on.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module dcps_top
  import dcps_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Oscillators
  input  wire logic               rc_clk_in,
  input  wire logic               xt_clk_in,
  // Display clock
  output logic                    display_clk,
  output logic                    display_tick,
  // Segment pins
  input  wire logic [SEG_HI:SEG_LO] seg_data,
  input  wire logic [SEG_HI:SEG_LO] gpio_out,
  input  wire logic [SEG_HI:SEG_LO] gpio_oe_n,
  output logic [SEG_HI:SEG_LO]      seg_pad_o,
  output logic [SEG_HI:SEG_LO]      seg_pad_oe_n,
  // Common pins
  input  wire logic [COM_N-1:0]   com_select,
  output logic [COM_N-1:0]        com_out,
  output logic                    com_high_sink,
  // Mode and touch sharing
  output logic                    led_mode,
  output logic                    driver_on,
  input  wire logic               touch_sense_active,
  output logic                    touch_conflict
);

  localparam int DEAD_MAX = 130;

  // ******************************
  // Register state
  // ******************************
  logic [7:0]      disp_ctrl_r, disp_ctrl_nxt;
  logic [7:0]      clk_mode_r, clk_mode_nxt;
  logic [7:0]      seg_pin_r, seg_pin_nxt;
  logic [31:0]     rdata_r, rdata_nxt;
  logic            conflict_r, conflict_nxt;
  logic            sink_r, sink_nxt;
  dcps_com_state_t st_r, st_nxt;
  logic [6:0]      dcnt_r, dcnt_nxt;
  logic [COM_N-1:0] prev_r, prev_nxt;
  logic [COM_N-1:0] com_r, com_nxt;

  logic       on, led, pol, dte;
  logic [7:0] status;
  logic       hit, wr_en, setup;
  logic [7:0] sel_data;
  logic       inact;

  assign on  = disp_ctrl_r[ON_BIT];
  assign led = clk_mode_r[LED_BIT];
  assign pol = clk_mode_r[POL_BIT];
  assign dte = clk_mode_r[DTE_BIT];

  // ******************************
  // APB slave
  // ******************************
  always_comb begin
    hit = (paddr == ADDR_DISP_CTRL) || (paddr == ADDR_CLK_MODE) ||
          (paddr == ADDR_SEG_PIN) || (paddr == ADDR_STATUS);
  end

  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite & hit;
  // Zero wait: read data is taken in setup, writes never stall
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always_comb begin
    status                = 8'h00;
    status[CONFLICT_BIT]  = conflict_r;
    status[DCLK_BIT]      = display_clk;
    status[DEAD_BIT]      = (st_r == CM_DEAD);
    case (paddr)
      ADDR_DISP_CTRL: sel_data = disp_ctrl_r;
      ADDR_CLK_MODE:  sel_data = clk_mode_r;
      ADDR_SEG_PIN:   sel_data = seg_pin_r;
      ADDR_STATUS:    sel_data = status;
      default:        sel_data = 8'h00;
    endcase
    // Read data captured in setup so the access phase needs no wait
    rdata_nxt = setup ? {24'h000000, sel_data} : rdata_r;
    disp_ctrl_nxt = disp_ctrl_r;
    clk_mode_nxt  = clk_mode_r;
    seg_pin_nxt   = seg_pin_r;
    if (wr_en && paddr == ADDR_DISP_CTRL) begin
      disp_ctrl_nxt = pwdata[7:0] & DISP_CTRL_WMASK; // RULE10
    end
    if (wr_en && paddr == ADDR_CLK_MODE) begin
      clk_mode_nxt = pwdata[7:0] & CLK_MODE_WMASK;
    end
    if (wr_en && paddr == ADDR_SEG_PIN) begin
      seg_pin_nxt = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_ctrl_r <= DISP_CTRL_RST;
      clk_mode_r  <= CLK_MODE_RST;
      seg_pin_r   <= SEG_PIN_RST;
      rdata_r     <= 32'h00000000;
    end else begin
      disp_ctrl_r <= disp_ctrl_nxt;
      clk_mode_r  <= clk_mode_nxt;
      seg_pin_r   <= seg_pin_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign prdata = rdata_r;

  // ******************************
  // Display clock
  // ******************************
  // Switching source mid-count may add one stray edge; software
  // should change the source while the driver is off.
  dcps_prescaler u_psc (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (on), // RULE10
    .src_sel    (clk_mode_r[CKS_BIT]),
    .psc_sel    (clk_mode_r[PSC_HI:PSC_LO]),
    .rc_in      (rc_clk_in),
    .xt_in      (xt_clk_in),
    .disp_clk_o (display_clk),
    .tick_o     (display_tick)
  );

  // ******************************
  // Segment pin select
  // ******************************
  for (genvar i = SEG_LO; i <= SEG_HI; i++) begin : g_pin
    localparam int EN_BIT = (i <= 7) ? 0 : (i <= 11) ? 1 : i - 10;
    // Group bits 0 and 1 cover four pins each, the rest one pin
    dcps_pin_cell u_cell ( // RULE3 RULE4 RULE5
      .pclk      (pclk),
      .presetn   (presetn),
      .seg_mode  (seg_pin_r[EN_BIT]),
      .seg_val   (seg_data[i] & on),
      .gpio_val  (gpio_out[i]),
      .gpio_oe_n (gpio_oe_n[i]),
      .pad_o     (seg_pad_o[i]),
      .pad_oe_n  (seg_pad_oe_n[i])
    );
  end

  // ******************************
  // Touch sharing and polarity
  // ******************************
  always_comb begin
    // Flag only; the hardware cannot stop software taking the pin
    conflict_nxt = seg_pin_r[1] & touch_sense_active; // RULE6
    sink_nxt     = led & ~pol; // RULE8
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conflict_r <= 1'b0;
      sink_r     <= 1'b0;
    end else begin
      conflict_r <= conflict_nxt;
      sink_r     <= sink_nxt;
    end
  end

  assign touch_conflict = conflict_r;
  assign com_high_sink  = sink_r;
  assign led_mode       = led; // RULE7
  assign driver_on      = on;

  // ******************************
  // Common outputs and dead time
  // ******************************
  always_comb begin
    st_nxt   = st_r;
    dcnt_nxt = dcnt_r;
    prev_nxt = com_select;
    inact    = led & ~pol;
    // A select change inside the dead time does not restart it
    case (st_r)
      CM_RUN: begin
        if (on && led && dte && com_select != prev_r) begin
          st_nxt   = CM_DEAD; // RULE9
          dcnt_nxt = DEAD_CNT;
        end
      end
      CM_DEAD: begin
        if (!(on && led && dte) || dcnt_r == 7'h01) begin
          st_nxt = CM_RUN;
        end else begin
          dcnt_nxt = dcnt_r - 7'h01;
        end
      end
      default: st_nxt = CM_RUN;
    endcase
    if (!on || st_nxt == CM_DEAD) begin
      com_nxt = {COM_N{inact}}; // RULE10
    end else if (led) begin
      com_nxt = pol ? com_select : ~com_select; // RULE8
    end else begin
      com_nxt = com_select; // RULE7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= CM_RUN;
      dcnt_r <= 7'h00;
      prev_r <= '0;
      com_r  <= '0;
    end else begin
      st_r   <= st_nxt;
      dcnt_r <= dcnt_nxt;
      prev_r <= prev_nxt;
      com_r  <= com_nxt;
    end
  end

  assign com_out = com_r;

  // ******************************
  // Checks
  // ******************************
  // Pads and commons are registered, so checks look one cycle on
  AST_GRP_LOW: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    seg_pin_r[0] |=> seg_pad_oe_n[7:4] == 4'h0)
    else $error("low group not given to display");
  AST_PAD_VAL: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    seg_pin_r[0] |=> seg_pad_o[7:4] == $past(seg_data[7:4] & {4{on}}))
    else $error("low group pad value wrong");
  AST_GRP_MID: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    !seg_pin_r[1] |=> seg_pad_oe_n[11:8] == $past(gpio_oe_n[11:8]))
    else $error("mid group not left as io");
  AST_GRP_MID_ON: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    seg_pin_r[1] |=> seg_pad_oe_n[11:8] == 4'h0)
    else $error("mid group not given to display");
  AST_SINGLE: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    (seg_pin_r[2] && !seg_pin_r[7]) |=>
      (!seg_pad_oe_n[12] && seg_pad_oe_n[17] == $past(gpio_oe_n[17])))
    else $error("single pin enable wrong");
  AST_TOUCH: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (seg_pin_r[1] && touch_sense_active) |=> touch_conflict)
    else $error("touch conflict not flagged");
  AST_TOUCH_CLR: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    !(seg_pin_r[1] && touch_sense_active) |=> !touch_conflict)
    else $error("touch conflict flagged without cause");
  AST_LCD_SINK: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    !led |=> !com_high_sink)
    else $error("high sink in lcd mode");
  AST_LCD_COM: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    (on && !led) |=> com_out == $past(com_select))
    else $error("lcd commons wrong");
  AST_POL: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (on && led && pol && st_r == CM_RUN && !dte) |=> com_out == $past(com_select))
    else $error("active high commons wrong");
  AST_LED_ACT_LOW: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (on && led && !pol && !dte) |=> com_out == ~$past(com_select))
    else $error("active low commons wrong");
  AST_LED_SINK: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (led && !pol) |=> com_high_sink)
    else $error("high sink missing in active low led mode");
  // Polarity of the cycle that blanked; a write may change it meanwhile
  AST_DEAD_BLANK: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    (st_r == CM_DEAD) |-> com_out == {COM_N{~$past(pol)}})
    else $error("commons not blanked in dead time");
  AST_DEAD_LEN: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    $rose(st_r == CM_DEAD) |-> ##[1:DEAD_MAX] (st_r == CM_RUN))
    else $error("dead time too long");
  AST_OFF: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    !on |=> (!display_clk && com_out == {COM_N{$past(inact)}}))
    else $error("driver not off");
  COV_DEAD: cover property (@(posedge pclk) disable iff (!presetn) $rose(st_r == CM_DEAD));
  COV_LOW: cover property (@(posedge pclk) disable iff (!presetn) seg_pin_r[0] && on);
  COV_TOUCH: cover property (@(posedge pclk) disable iff (!presetn) touch_conflict);
  COV_LED_INV: cover property (@(posedge pclk) disable iff (!presetn) on && led && !pol);

endmodule
`default_nettype wire

// ---- hw/dcps_pkg.sv ----
// Constants for the display clock and segment pin select block.
// Assumes a 250 MHz APB clock and 8-bit registers in the low byte of each word.
package dcps_pkg;

  // ******************************
  // Register indices and addresses
  // ******************************
  localparam logic [7:0]  IDX_DISP_CTRL  = 8'hb1;
  localparam logic [7:0]  IDX_CLK_MODE   = 8'hb2;
  localparam logic [7:0]  IDX_SEG_PIN    = 8'hb3;
  localparam logic [7:0]  IDX_STATUS     = 8'hb4;
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] ADDR_DISP_CTRL = {2'h0, IDX_DISP_CTRL, 2'h0};
  localparam logic [11:0] ADDR_CLK_MODE  = {2'h0, IDX_CLK_MODE, 2'h0};
  localparam logic [11:0] ADDR_SEG_PIN   = {2'h0, IDX_SEG_PIN, 2'h0};
  localparam logic [11:0] ADDR_STATUS    = {2'h0, IDX_STATUS, 2'h0};

  // ******************************
  // Field positions, masks, resets
  // ******************************
  localparam int         ON_BIT       = 7;
  localparam int         CKS_BIT      = 7;
  localparam int         PSC_HI       = 6;
  localparam int         PSC_LO       = 5;
  localparam int         LED_BIT      = 4;
  localparam int         POL_BIT      = 3;
  localparam int         DTE_BIT      = 2;
  localparam int         CONFLICT_BIT = 0;
  localparam int         DCLK_BIT     = 1;
  localparam int         DEAD_BIT     = 2;
  localparam logic [7:0] DISP_CTRL_WMASK = 8'h80;
  localparam logic [7:0] CLK_MODE_WMASK  = 8'hfc;
  localparam logic [7:0] DISP_CTRL_RST   = 8'h00;
  localparam logic [7:0] CLK_MODE_RST    = 8'h00;
  localparam logic [7:0] SEG_PIN_RST     = 8'h00;

  // ******************************
  // Pins
  // ******************************
  localparam int SEG_LO   = 4;
  localparam int SEG_HI   = 17;
  localparam int COM_N    = 4;
  localparam int PSC_CNTW = 8;

  // ******************************
  // Timing
  // ******************************
  localparam int         CLK_PERIOD_NS = 4;
  localparam int         DEAD_TIME_NS  = 500;
  localparam int         DEAD_CYCLES   = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] DEAD_CNT      = 7'(DEAD_CYCLES);

  typedef enum logic {
    CM_RUN  = 1'b0,
    CM_DEAD = 1'b1
  } dcps_com_state_t;

endpackage

// ---- hw/dcps_prescaler.sv ----
// Clock source select and prescaler for the display clock.
// Assumes both slow oscillator levels are synchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
module dcps_prescaler
  import dcps_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       run,
  input  wire logic       src_sel,
  input  wire logic [1:0] psc_sel,
  // Oscillator levels
  input  wire logic       rc_in,
  input  wire logic       xt_in,
  // Divided clock
  output logic            disp_clk_o,
  output logic            tick_o
);

  logic                prev_r, prev_nxt;
  logic [PSC_CNTW-1:0] cnt_r, cnt_nxt;
  logic                out_r, out_nxt;
  logic                tick_r, tick_nxt;
  logic                src_lvl;

  always_comb begin
    src_lvl  = src_sel ? xt_in : rc_in; // RULE1
    prev_nxt = src_lvl;
    cnt_nxt  = cnt_r;
    if (!run) begin
      cnt_nxt = '0;
    end else if (src_lvl && !prev_r) begin
      cnt_nxt = cnt_r + 8'h01;
    end
    // Counter bit 7 halves 256 edges; each higher code takes one bit less
    out_nxt  = run & cnt_nxt[3'd7 - {1'b0, psc_sel}]; // RULE2
    tick_nxt = out_nxt & ~out_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b0;
      cnt_r  <= '0;
      out_r  <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      cnt_r  <= cnt_nxt;
      out_r  <= out_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign disp_clk_o = out_r;
  assign tick_o     = tick_r;

  AST_SRC_XT_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    (run && src_sel && $past(src_sel) && !xt_in) |-> ##1 cnt_r == $past(cnt_r))
    else $error("crystal source ignored");
  AST_SRC_RC_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    (run && !src_sel && !$past(src_sel) && !rc_in) |-> ##1 cnt_r == $past(cnt_r))
    else $error("rc source ignored");
  // A rise of the divided clock lands where all bits below the tap are zero
  AST_PSC_TAP: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    (run && $stable(psc_sel) && $past(psc_sel, 2) == psc_sel && $rose(out_r)) |->
      (cnt_r & ((8'h80 >> psc_sel) - 8'h01)) == 8'h00)
    else $error("prescaler tap wrong");

endmodule
`default_nettype wire

// ---- hw/dcps_pin_cell.sv ----
// One shared port pin: general I/O or display segment drive.
// Assumes the pad resolves its level from the active-low enable.
`timescale 1ns/10ps
`default_nettype none
module dcps_pin_cell (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Selection
  input  wire logic seg_mode,
  // Sources
  input  wire logic seg_val,
  input  wire logic gpio_val,
  input  wire logic gpio_oe_n,
  // Pad
  output logic      pad_o,
  output logic      pad_oe_n
);

  logic o_r, o_nxt;
  logic oe_n_r, oe_n_nxt;

  always_comb begin
    o_nxt    = seg_mode ? seg_val : gpio_val;
    oe_n_nxt = seg_mode ? 1'b0 : gpio_oe_n;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      o_r    <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      o_r    <= o_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign pad_o    = o_r;
  assign pad_oe_n = oe_n_r;

endmodule
`default_nettype wire

// ---- verification/test_dcps_top.sv ----
// Self-checking bench for the display clock and segment pin select block.
// Assumes a zero-wait APB slave, one byte per register and slow sources
// that the bench makes as levels synchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
module test_dcps_top
  import dcps_pkg::*;
;
  logic                     pclk = 1'b0, presetn = 1'b0;
  logic                     psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0]        paddr = '0;
  logic [31:0]              pwdata = '0, prdata;
  logic                     pready, pslverr, display_clk, display_tick;
  logic                     rc_clk_in = 1'b0, xt_clk_in = 1'b0;
  logic [SEG_HI:SEG_LO]     seg_data = 14'h2dcb, gpio_out = 14'h1234, gpio_oe_n = 14'h0f0f;
  logic [SEG_HI:SEG_LO]     seg_pad_o, seg_pad_oe_n;
  logic [COM_N-1:0]         com_select = '0, com_out;
  logic                     com_high_sink, led_mode, driver_on, touch_conflict;
  logic                     touch_sense_active = 1'b0;
  int                       num_errors = 0, check_count = 0;
  int                       cyc = 0, rc_rises = 0, xt_rises = 0;

  dcps_top u_dcps_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_clk_in(rc_clk_in), .xt_clk_in(xt_clk_in), .display_clk(display_clk),
    .display_tick(display_tick), .seg_data(seg_data), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .seg_pad_o(seg_pad_o), .seg_pad_oe_n(seg_pad_oe_n),
    .com_select(com_select), .com_out(com_out), .com_high_sink(com_high_sink),
    .led_mode(led_mode), .driver_on(driver_on), .touch_sense_active(touch_sense_active),
    .touch_conflict(touch_conflict)
  );

  always #2 pclk = ~pclk;

  // Two sources at different rates, so a wrong source shows in the count
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    rc_clk_in <= (cyc % 4) < 2;
    xt_clk_in <= (cyc % 6) < 3;
    if (cyc % 4 == 0) rc_rises <= rc_rises + 1;
    if (cyc % 6 == 0) xt_rises <= xt_rises + 1;
  end

  // ******************************
  // Shared tasks
  // ******************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) check(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 8'h00, rd, e);
    check(rd, exp);
    check(32'(e), 32'(eexp));
  endtask

  task automatic wait_tick;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (display_tick !== 1'b1 && n < 5000);
    if (n >= 5000) check(32'h0, 32'h1);
  endtask

  // ******************************
  // Scenarios
  // ******************************
  task automatic t_regs;
    rdc(ADDR_DISP_CTRL, 32'h0, 1'b0);
    rdc(ADDR_CLK_MODE, 32'h0, 1'b0);
    rdc(ADDR_SEG_PIN, 32'h0, 1'b0);
    wr(ADDR_CLK_MODE, 8'hff);
    rdc(ADDR_CLK_MODE, 32'hfc, 1'b0);
    wr(ADDR_SEG_PIN, 8'ha5);
    rdc(ADDR_SEG_PIN, 32'ha5, 1'b0);
    wr(ADDR_DISP_CTRL, 8'hff);
    rdc(ADDR_DISP_CTRL, 32'h80, 1'b0);
    rdc(12'h100, 32'h0, 1'b1);
    wr(ADDR_CLK_MODE, 8'h00);
    wr(ADDR_SEG_PIN, 8'h00);
  endtask

  task automatic t_pins(input logic on);
    logic [SEG_HI:SEG_LO] m;
    wr(ADDR_DISP_CTRL, {on, 7'h0});
    for (int b = 0; b < 8; b++) begin
      m = '0;
      if (b == 0) m[7:4] = '1;
      else if (b == 1) m[11:8] = '1;
      else m[10+b] = 1'b1;
      wr(ADDR_SEG_PIN, 8'h01 << b);
      cycles(3);
      check(32'(seg_pad_o), 32'((seg_data & m & {14{on}}) | (gpio_out & ~m)));
      check(32'(seg_pad_oe_n), 32'(gpio_oe_n & ~m));
    end
  endtask

  task automatic t_touch;
    touch_sense_active <= 1'b1;
    wr(ADDR_SEG_PIN, 8'h02);
    cycles(3);
    check(32'(touch_conflict), 32'h1);
    rdc(ADDR_STATUS, 32'h00000001, 1'b0);
    wr(ADDR_SEG_PIN, 8'h01);
    cycles(3);
    check(32'(touch_conflict), 32'h0);
    wr(ADDR_SEG_PIN, 8'h02);
    touch_sense_active <= 1'b0;
    cycles(3);
    check(32'(touch_conflict), 32'h0);
  endtask

  task automatic com_case(input logic [7:0] md, input logic on, input logic [3:0] ec,
                          input logic es);
    wr(ADDR_CLK_MODE, md);
    wr(ADDR_DISP_CTRL, {on, 7'h0});
    cycles(3);
    check(32'(com_out), 32'(ec));
    check(32'(com_high_sink), 32'(es));
    check(32'(led_mode), 32'(md[LED_BIT]));
    check(32'(driver_on), 32'(on));
  endtask

  task automatic t_com;
    com_select <= 4'h4;
    com_case(8'h00, 1'b1, 4'h4, 1'b0);
    com_case(8'h10, 1'b1, 4'hb, 1'b1);
    com_case(8'h18, 1'b1, 4'h4, 1'b0);
    com_case(8'h10, 1'b0, 4'hf, 1'b1);
    com_case(8'h00, 1'b0, 4'h0, 1'b0);
  endtask

  task automatic t_dead;
    logic [31:0] rd;
    logic        e;
    wr(ADDR_DISP_CTRL, 8'h80);
    wr(ADDR_CLK_MODE, 8'h1c);
    com_select <= 4'h1;
    cycles(200);
    check(32'(com_out), 32'h1);
    com_select <= 4'h2;
    cycles(5);
    check(32'(com_out), 32'h0);
    apb(1'b0, ADDR_STATUS, 8'h00, rd, e);
    check(rd & 32'h4, 32'h4);
    cycles(110);
    check(32'(com_out), 32'h0);
    cycles(30);
    check(32'(com_out), 32'h2);
    wr(ADDR_CLK_MODE, 8'h18);
    com_select <= 4'h8;
    cycles(3);
    check(32'(com_out), 32'h8);
  endtask

  task automatic t_clk;
    int a;
    wr(ADDR_DISP_CTRL, 8'h00);
    cycles(600);
    check(32'(display_clk), 32'h0);
    wr(ADDR_DISP_CTRL, 8'h80);
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        wr(ADDR_CLK_MODE, {s[0], c[1:0], 5'h00});
        wait_tick;
        wait_tick;
        a = s ? xt_rises : rc_rises;
        wait_tick;
        check(32'((s ? xt_rises : rc_rises) - a), 32'(256 >> c));
      end
    end
  endtask

  task automatic t_reset;
    wr(ADDR_SEG_PIN, 8'hff);
    presetn <= 1'b0;
    cycles(2);
    check(32'(seg_pad_oe_n), 32'h3fff);
    check(32'(com_out), 32'h0);
    presetn <= 1'b1;
    rdc(ADDR_SEG_PIN, 32'h0, 1'b0);
  endtask

  // ******************************
  // Run control
  // ******************************
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    check(32'(seg_pad_oe_n), 32'h3fff);
    check(32'(driver_on), 32'h0);
    presetn <= 1'b1;
    t_regs;
    t_pins(1'b1);
    t_pins(1'b0);
    t_touch;
    t_com;
    t_dead;
    t_clk;
    t_reset;
    summarize;
  end

  // Tests need at most about 16k cycles; the 75k-cycle limit allows over four times that
  initial begin
    #300000;
    num_errors++;
    summarize;
  end
endmodule
`default_nettype wire
